/* File: verification/bx_far.sv */
// backplane model: arbitration clock, priority resolver and the other masters
`timescale 1ns/10ps
module bx_far
    import bx_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire bx_pins_out_t pins_out,
    input  wire logic         serial_mode,
    input  wire logic         up_deny,
    input  wire logic         other_req,
    input  wire logic         other_held,
    input  wire logic         low_req,
    output bx_pins_in_t       pins_in
);
    logic [1:0] div_r;
    logic       bclk_r;

    // free running bus clock, one fall every eight system cycles
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            div_r  <= 2'h0;
            bclk_r <= 1'b1;
        end else begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'h3) begin
                bclk_r <= ~bclk_r;
            end
        end
    end

    assign pins_in.bus_clk_n = bclk_r;
    // other_req stands for a higher master, so in parallel mode it always wins the grant
    // serial chain here is one master under a strap, well inside the chain limit
    assign pins_in.priority_in_n = serial_mode ? up_deny
                                 : (pins_out.bus_request_n | other_req);
    // wired-or busy and common request lines, pulled up when nobody drives
    assign pins_in.bus_held_n = ~(pins_out.bus_held_oe | other_held);
    assign pins_in.common_request_n = ~(pins_out.common_request_oe | other_req | low_req);
endmodule

/* File: verification/tb_bx_exchange.sv */
// scenario bench of the bus exchange block against its backplane model
`timescale 1ns/10ps
module tb_bx_exchange;
    import bx_pkg::*;
    logic         clk_sys;
    logic         arst_n;
    bx_pins_in_t  pins_in;
    bx_pins_out_t pins_out;
    logic         serial_mode, need_bus, cmd_active, bus_lock, bus_owned, drivers_en;
    logic         up_deny, other_req, other_held, low_req;
    int           n_fail;
    int           checks;

    bx_exchange i_dut (.clk_sys, .arst_n, .pins_in, .pins_out, .serial_mode, .need_bus,
                       .cmd_active, .bus_lock, .bus_owned, .drivers_en);
    bx_far i_far (.clk_sys, .arst_n, .pins_out, .serial_mode, .up_deny, .other_req,
                  .other_held, .low_req, .pins_in);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic exp, input logic got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // bounded wait for ownership, then the three holder outputs together
    task automatic own_within(input logic exp);
        int i;
        i = 0;
        while (bus_owned !== exp && i < 200) begin
            @(negedge clk_sys);
            i++;
        end
        chk("bus_owned", exp, bus_owned);
        chk("drivers_en", exp, drivers_en);
        chk("bus_held_oe", exp, pins_out.bus_held_oe);
    endtask

    task automatic t_reset;
        chk("bus_request_n", 1'b1, pins_out.bus_request_n);
        chk("common_request_oe", 1'b0, pins_out.common_request_oe);
        own_within(1'b0);
    endtask

    task automatic t_take;
        need_bus = 1'b1;
        repeat (20) if (pins_out.bus_request_n) @(negedge clk_sys);
        chk("bus_request_n", 1'b0, pins_out.bus_request_n);
        chk("bus_owned", 1'b0, bus_owned);
        chk("common_request_oe", 1'b1, pins_out.common_request_oe);
        chk("common_request_o", 1'b0, pins_out.common_request_o);
        own_within(1'b1);
        chk("bus_held_o", 1'b0, pins_out.bus_held_o);
        chk("common_request_oe", 1'b0, pins_out.common_request_oe);
        chk("priority_out_oe", 1'b0, pins_out.priority_out_oe);
    endtask

    task automatic t_keep_finish;
        need_bus = 1'b0;
        cyc(40);
        chk("bus_owned", 1'b1, bus_owned);
        cmd_active = 1'b1;
        other_req = 1'b1;
        cyc(40);
        chk("bus_owned", 1'b1, bus_owned);
        cmd_active = 1'b0;
        own_within(1'b0);
        other_req = 1'b0;
    endtask

    task automatic t_busy_lock;
        other_held = 1'b1;
        need_bus = 1'b1;
        cyc(40);
        chk("bus_owned", 1'b0, bus_owned);
        other_held = 1'b0;
        own_within(1'b1);
        bus_lock = 1'b1;
        other_req = 1'b1;
        cyc(40);
        chk("bus_owned", 1'b1, bus_owned);
        bus_lock = 1'b0;
        own_within(1'b0);
        other_req = 1'b0;
        own_within(1'b1);
    endtask

    task automatic t_recontend;
        low_req = 1'b1;
        own_within(1'b0);
        own_within(1'b1);
        need_bus = 1'b0;
        own_within(1'b0);
        low_req = 1'b0;
    endtask

    task automatic t_serial;
        serial_mode = 1'b1;
        up_deny = 1'b1;
        cyc(20);
        chk("priority_out_oe", 1'b1, pins_out.priority_out_oe);
        chk("priority_out_n", 1'b1, pins_out.priority_out_n);
        up_deny = 1'b0;
        cyc(20);
        chk("priority_out_n", 1'b0, pins_out.priority_out_n);
        need_bus = 1'b1;
        cyc(20);
        chk("priority_out_n", 1'b1, pins_out.priority_out_n);
        chk("bus_request_n", 1'b1, pins_out.bus_request_n);
        own_within(1'b1);
    endtask

    task automatic stop_test;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        n_fail = 0;
        checks = 0;
        arst_n = 1'b0;
        {serial_mode, need_bus, cmd_active, bus_lock} = 4'h0;
        {up_deny, other_req, other_held, low_req} = 4'h0;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        arst_n = 1'b1;
        t_reset;
        t_take;
        t_keep_finish;
        t_busy_lock;
        t_recontend;
        t_serial;
        stop_test;
    end

    // whole run needs a few hundred cycles; 100us is 20000 cycles, a generous bound
    initial begin
        #100us;
        n_fail++;
        stop_test;
    end
endmodule

/* File: verilog/bx_exchange.sv */
// bus exchange logic of one master on a shared multi-master backplane
//
// What this block does
// - a requesting master drives priority_out_n high to lower masters.
// - a high priority_in_n is passed on as a high priority_out_n.
// - in serial mode bus_request_n stays inside the master.
// - in parallel mode priority_out_n is not driven onto the backplane.
// - local need is synchronised to the falling arbitration clock edge.
// - a holder that loses priority finishes the running command first.
// - after the command, release bus_held_n and drivers on next falling edge.
// - a granted master takes the bus on the falling edge after bus free.
// - bus lock keeps bus_held_n active even without priority.
// - single master system should keep bus lock asserted all the time.
// - with common request idle and priority kept, the holder keeps the bus between accesses.
// - with common request active, holder releases after access and recontends.
`timescale 1ns/10ps
`include "bx_map.svh"

module bx_exchange
    import bx_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          arst_n,
    input  wire bx_pins_in_t   pins_in,
    output bx_pins_out_t       pins_out,
    input  wire logic          serial_mode,
    input  wire logic          need_bus,
    input  wire logic          cmd_active,
    input  wire logic          bus_lock,
    output logic               bus_owned,
    output logic               drivers_en
);

    bx_pins_in_t  pins_s;
    bx_state_t    state_r;
    bx_state_t    state_nxt;
    bx_pins_out_t out_r;
    logic         bclk_d_r;
    logic         req_r;
    logic         req_nxt;
    logic         bus_fall;
    logic         prio_ok;
    logic         bus_free;
    logic         common_request_n_act;
    logic         release_now;
    logic         take_now;

    bx_sync #(
        .W       (`BX_PIN_IN_W)
    ) u_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .d       (pins_in),
        .q       (pins_s)
    );

    // the arbitration clock is just another pin level here; only its
    // high-to-low transitions move the exchange sequence
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bclk_d_r <= `BX_PIN_IDLE;
        end else begin
            bclk_d_r <= pins_s.bus_clk_n;
        end
    end

    assign bus_fall = bclk_d_r & ~pins_s.bus_clk_n;
    assign prio_ok  = (pins_s.priority_in_n == `BX_PIN_ACTIVE);
    assign bus_free = (pins_s.bus_held_n == `BX_PIN_IDLE);
    assign common_request_n_act = (pins_s.common_request_n == `BX_PIN_ACTIVE);

    // a running command is never cut; lock overrides both priority loss
    // and a pending common request
    assign release_now = !cmd_active && !bus_lock && (!prio_ok || common_request_n_act);
    assign take_now    = req_r && prio_ok && bus_free;

    // request is sampled only at falling edges; a holder keeps it up so a
    // parallel resolver keeps granting it until the release
    always_comb begin
        req_nxt = req_r;
        if (bus_fall) begin
            if (state_r == BX_OWN) begin
                req_nxt = !release_now;
            end else begin
                req_nxt = need_bus;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            req_r <= 1'b0;
        end else begin
            req_r <= req_nxt;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BX_IDLE: begin
                if (bus_fall && need_bus) begin
                    state_nxt = BX_WAIT;
                end
            end
            BX_WAIT: begin
                if (bus_fall) begin
                    if (take_now) begin
                        state_nxt = BX_OWN;
                    end else if (!need_bus) begin
                        state_nxt = BX_IDLE;
                    end
                end
            end
            BX_OWN: begin
                // holding with common request idle and priority kept: stay
                if (bus_fall && release_now) begin
                    state_nxt = BX_IDLE;
                end
            end
            default: begin
                state_nxt = BX_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= BX_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ownership and drivers follow the state the same edge it changes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bus_owned  <= 1'b0;
            drivers_en <= 1'b0;
        end else begin
            bus_owned  <= (state_nxt == BX_OWN);
            drivers_en <= (state_nxt == BX_OWN);
        end
    end

    // backplane drive; bus_held_n and common request are open-drain lows
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_r.bus_request_n     <= `BX_PIN_IDLE;
            out_r.priority_out_n    <= `BX_PIN_IDLE;
            out_r.priority_out_oe   <= 1'b0;
            out_r.bus_held_o        <= `BX_PIN_ACTIVE;
            out_r.bus_held_oe       <= 1'b0;
            out_r.common_request_o  <= `BX_PIN_ACTIVE;
            out_r.common_request_oe <= 1'b0;
        end else begin
            // the chain carries priority, so the request pin stays quiet
            out_r.bus_request_n     <= (serial_mode || !req_nxt) ? `BX_PIN_IDLE
                                                                 : `BX_PIN_ACTIVE;
            // deny downstream while requesting, holding or denied ourselves
            out_r.priority_out_n    <= (req_nxt || state_nxt == BX_OWN || !prio_ok)
                                       ? `BX_PIN_IDLE : `BX_PIN_ACTIVE;
            // backplane ties this pin to a neighbour's grant in parallel mode
            out_r.priority_out_oe   <= serial_mode;
            out_r.bus_held_o        <= `BX_PIN_ACTIVE;
            out_r.bus_held_oe       <= (state_nxt == BX_OWN);
            out_r.common_request_o  <= `BX_PIN_ACTIVE;
            out_r.common_request_oe <= (state_nxt == BX_WAIT);
        end
    end

    assign pins_out = out_r;

    // priority tie-off and a permanently held lock are board
    // straps; holding bus_lock high keeps this master as owner for good

    a_req_on_fall: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (req_r != $past(req_r)) |-> $past(bus_fall))
        else $error("request changed without a falling arbitration edge");

    a_take_needs_grant: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ($past(state_r) == BX_WAIT && state_r == BX_OWN)
        |-> $past(bus_fall && prio_ok && bus_free)
            && pins_out.bus_held_oe && drivers_en)
        else $error("bus taken without grant, free bus or falling edge");

    a_cmd_not_cut: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_r == BX_OWN && cmd_active) |=> state_r == BX_OWN)
        else $error("bus released during a running command");

    // a sampled lock guards only the decision of that edge; it may drop right after
    a_lock_keeps_bus: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_r == BX_OWN && bus_lock) |=> state_r == BX_OWN && pins_out.bus_held_oe)
        else $error("locked holder lost the bus");

    a_release_on_fall: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ($past(state_r) == BX_OWN && state_r != BX_OWN)
        |-> $past(bus_fall) && !drivers_en ##1 !pins_out.bus_held_oe)
        else $error("release not aligned to falling edge");

    a_deny_when_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
        req_r |-> pins_out.priority_out_n)
        else $error("priority passed down while requesting");

    a_deny_passed_down: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!prio_ok && $stable(pins_s.priority_in_n)) |=> pins_out.priority_out_n)
        else $error("denied priority not propagated");

    a_par_out_undriven: assert property (@(posedge clk_sys) disable iff (!arst_n)
        !serial_mode |=> !pins_out.priority_out_oe)
        else $error("priority out driven in parallel mode");

    a_serial_req_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
        serial_mode |=> pins_out.bus_request_n)
        else $error("request pin driven in serial mode");

    a_keep_when_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_r == BX_OWN && !common_request_n_act && prio_ok) |=> state_r == BX_OWN)
        else $error("bus dropped with no other requester");

    a_yield_on_common_request_n: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (state_r == BX_OWN && bus_fall && common_request_n_act && !cmd_active && !bus_lock)
        |=> state_r == BX_IDLE && !req_r)
        else $error("holder kept bus against common request");

endmodule

/* File: verilog/bx_map.svh */
// constants of the bus exchange block: idle pin levels and synchroniser depth
`ifndef BX_MAP_SVH
`define BX_MAP_SVH

`define BX_PIN_IDLE     1'b1
`define BX_PIN_ACTIVE   1'b0
`define BX_SYNC_STAGES  2
`define BX_PIN_IN_W     4

`endif

/* File: verilog/bx_pkg.sv */
// types of the bus exchange block
package bx_pkg;

    typedef enum logic [1:0] {
        BX_IDLE,
        BX_WAIT,
        BX_OWN
    } bx_state_t;

    // backplane levels seen by the master, all active low
    typedef struct packed {
        logic bus_clk_n;
        logic priority_in_n;
        logic bus_held_n;
        logic common_request_n;
    } bx_pins_in_t;

    // backplane drive, open-drain lines as level plus enable
    typedef struct packed {
        logic bus_request_n;
        logic priority_out_n;
        logic priority_out_oe;
        logic bus_held_o;
        logic bus_held_oe;
        logic common_request_o;
        logic common_request_oe;
    } bx_pins_out_t;

endpackage

/* File: verilog/bx_sync.sv */
// two-flop synchroniser for backplane levels
`timescale 1ns/10ps
`include "bx_map.svh"

module bx_sync
    import bx_pkg::*;
#(
    parameter int W = `BX_PIN_IN_W
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    // idle level on reset so no false edge appears at release
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= {W{`BX_PIN_IDLE}};
            q      <= {W{`BX_PIN_IDLE}};
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule
